// ==== inc/ttrc_pkg.sv ====
// package of constants and carrier types for the tester timing and run control
// assumes one 250 MHz reference clock and an AXI4-Lite register slave with 32-bit data
package ttrc_pkg;

  // ----------------------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned MCLK_PERIOD_NS  = 100;
  localparam int unsigned MCLK_DIV        = (MCLK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned MCLK_HIGH       = (MCLK_DIV + 1) / 2;
  localparam int unsigned PH_W            = 5;
  localparam int unsigned TAPS            = 28;
  localparam int unsigned DIV_W           = TAPS - 1;
  localparam int unsigned FLASH_PERIOD_MS = 417;
  localparam int unsigned FLASH_TAP       = 22;

  // ----------------------------------------------------------------------------
  // rate selector layout
  // ----------------------------------------------------------------------------
  localparam int unsigned CMP_FIRST_TAP   = TAPS - 11;
  localparam int unsigned CMP_CHOICES     = 11;
  localparam int unsigned STIM_FIRST_TAP  = 3;
  localparam int unsigned STIM_CHOICES    = 11;
  localparam int unsigned SAMP_GAP_LO     = 7;
  localparam int unsigned SAMP_GAP_HI     = 17;
  localparam int unsigned SAMP_CHOICES    = 24;
  localparam int unsigned DLY_W           = 24;
  localparam int unsigned GEN_OUTS        = 66;
  localparam int unsigned SEQ_W           = 8;

  // ----------------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_RATE        = 8'h04;
  localparam logic [7:0]  REG_DELAY       = 8'h08;
  localparam logic [7:0]  REG_STAT        = 8'h0C;
  localparam logic [7:0]  REG_SEQ         = 8'h10;
  localparam int unsigned CTRL_MODE_BIT   = 0;
  localparam int unsigned RATE_CMP_LSB    = 0;
  localparam int unsigned RATE_STIM_LSB   = 8;
  localparam int unsigned RATE_SAMP_LSB   = 16;
  localparam int unsigned DLY_TRIM_LSB    = 0;
  localparam int unsigned DLY_RANGE_LSB   = 8;
  localparam int unsigned ST_MASTER_BIT   = 0;
  localparam int unsigned ST_GATE_BIT     = 1;
  localparam int unsigned ST_RUN_BIT      = 2;
  localparam int unsigned ST_LAMP_BIT     = 3;
  localparam int unsigned ST_FAIL_BIT     = 4;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [31:0] RATE_RST        = 32'h0000_0000;
  localparam logic [31:0] DELAY_RST       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic preset;
    logic halt;
    logic fault_clr;
  } ttrc_btn_t;

  typedef struct packed {
    logic [3:0] cmp;
    logic [3:0] stim;
    logic [4:0] samp;
    logic [2:0] range;
    logic [7:0] trim;
  } ttrc_sel_t;

endpackage

// ==== logic/ttrc_top.sv ====
// tester timing and run control: master clock gate, divider chain, rate selectors,
// strobe delay, run lamp, sequenced-pin counter and stimulus fan-out
// assumes front-panel and board-side inputs are asynchronous; registers over AXI4-Lite
`timescale 1ns/1ps

module ttrc_top (
  input  wire logic                              REF_CLK,
  input  wire logic                              RST_B,
  input  wire ttrc_pkg::ttrc_btn_t               BTN,
  input  wire logic                              INIT_DONE_B,
  input  wire logic                              FAIL,
  input  wire logic                              SYNC_RET,
  input  wire logic                              HOLD_RET,
  input  wire logic [ttrc_pkg::GEN_OUTS-1:0]     GEN_OUT,
  output logic                                   RUN_LAMP,
  output logic                                   CMP_STEP,
  output logic                                   SAMPLE_CLK,
  output logic                                   SAMPLE_STB,
  output logic                                   STIM_CLK,
  output logic                                   STIM_CLK_B,
  output logic                                   SYNC_OUT,
  output logic                                   HOLD_OUT,
  output logic [ttrc_pkg::SEQ_W-1:0]             SEQ_OUT,
  output logic [ttrc_pkg::GEN_OUTS-1:0]          REF_DRIVE,
  output logic [ttrc_pkg::GEN_OUTS-1:0]          DUT_DRIVE,
  input  wire logic [7:0]                        S_AXI_AWADDR,
  input  wire logic                              S_AXI_AWVALID,
  output logic                                   S_AXI_AWREADY,
  input  wire logic [31:0]                       S_AXI_WDATA,
  input  wire logic [3:0]                        S_AXI_WSTRB,
  input  wire logic                              S_AXI_WVALID,
  output logic                                   S_AXI_WREADY,
  output logic [1:0]                             S_AXI_BRESP,
  output logic                                   S_AXI_BVALID,
  input  wire logic                              S_AXI_BREADY,
  input  wire logic [7:0]                        S_AXI_ARADDR,
  input  wire logic                              S_AXI_ARVALID,
  output logic                                   S_AXI_ARREADY,
  output logic [31:0]                            S_AXI_RDATA,
  output logic [1:0]                             S_AXI_RRESP,
  output logic                                   S_AXI_RVALID,
  input  wire logic                              S_AXI_RREADY
);

  localparam int unsigned SW = 8 + ttrc_pkg::GEN_OUTS;
  localparam logic [SW-1:0] SYNC_RST = {4'h0, 4'h8, {ttrc_pkg::GEN_OUTS{1'b0}}};

  // ----------------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------------
  logic [SW-1:0]                  meta_q;
  logic [SW-1:0]                  sync_q;
  ttrc_pkg::ttrc_btn_t            btn;
  logic                           init_done_b;
  logic                           fail;
  logic                           sync_ret;
  logic                           hold_ret;
  logic [ttrc_pkg::GEN_OUTS-1:0]  gen_out;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end else begin
      meta_q <= {BTN, INIT_DONE_B, FAIL, SYNC_RET, HOLD_RET, GEN_OUT};
      sync_q <= meta_q;
    end
  end

  assign {btn, init_done_b, fail, sync_ret, hold_ret, gen_out} = sync_q;

  // ----------------------------------------------------------------------------
  // registers held by software
  // ----------------------------------------------------------------------------
  logic [31:0]         ctrl_q;
  logic [31:0]         rate_q;
  logic [31:0]         delay_q;
  logic                mode_seq;
  ttrc_pkg::ttrc_sel_t sel;

  assign mode_seq  = ctrl_q[ttrc_pkg::CTRL_MODE_BIT];
  assign sel.cmp   = rate_q[ttrc_pkg::RATE_CMP_LSB +: 4];
  assign sel.stim  = rate_q[ttrc_pkg::RATE_STIM_LSB +: 4];
  assign sel.samp  = rate_q[ttrc_pkg::RATE_SAMP_LSB +: 5];
  assign sel.trim  = delay_q[ttrc_pkg::DLY_TRIM_LSB +: 8];
  assign sel.range = delay_q[ttrc_pkg::DLY_RANGE_LSB +: 3];

  // ----------------------------------------------------------------------------
  // master clock flip-flop and glitch-free gate
  // ----------------------------------------------------------------------------
  logic                        master_q;
  logic                        gate_q;
  logic [ttrc_pkg::PH_W-1:0]   phase_q;
  logic                        ph_wrap;

  assign ph_wrap = (phase_q == ttrc_pkg::PH_W'(ttrc_pkg::MCLK_DIV - 1));

  // free-running 10 MHz phase, the oscillator never stops
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      phase_q <= '0;
    end else if (ph_wrap) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      master_q <= 1'b0;
    end else if (btn.halt || btn.fault_clr) begin
      master_q <= 1'b0;
    end else if (btn.preset || btn.start) begin
      master_q <= 1'b1;
    end
  end

  // gate only moves at the start of a master period so no pulse is cut short
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      gate_q <= 1'b0;
    end else if (ph_wrap) begin
      gate_q <= master_q;
    end
  end

  // ----------------------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------------------
  logic [ttrc_pkg::DIV_W-1:0] div_q;
  logic [ttrc_pkg::TAPS-1:0]  tap;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_q <= '0;
    end else if (gate_q && ph_wrap) begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tap[0] = gate_q && (phase_q < ttrc_pkg::PH_W'(ttrc_pkg::MCLK_HIGH));

  genvar gi;
  generate
    for (gi = 1; gi < ttrc_pkg::TAPS; gi++) begin : g_tap
      assign tap[gi] = div_q[gi-1];
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // rate selectors
  // ----------------------------------------------------------------------------
  logic [4:0] cmp_idx;
  logic [4:0] stim_idx;
  logic [4:0] samp_idx;

  // out-of-range switch codes stick at the last position
  always_comb begin
    if (sel.cmp < 4'(ttrc_pkg::CMP_CHOICES)) begin
      cmp_idx = 5'(ttrc_pkg::CMP_FIRST_TAP) + {1'b0, sel.cmp};
    end else begin
      cmp_idx = 5'(ttrc_pkg::TAPS - 1);
    end
    if (sel.stim < 4'(ttrc_pkg::STIM_CHOICES)) begin
      stim_idx = 5'(ttrc_pkg::STIM_FIRST_TAP) + {sel.stim, 1'b0};
    end else begin
      stim_idx = 5'(ttrc_pkg::STIM_FIRST_TAP + 2 * (ttrc_pkg::STIM_CHOICES - 1));
    end
    if (sel.samp >= 5'(ttrc_pkg::SAMP_CHOICES)) begin
      samp_idx = 5'(ttrc_pkg::TAPS - 3);
    end else if (sel.samp >= 5'(ttrc_pkg::SAMP_GAP_HI - 1)) begin
      samp_idx = sel.samp + 5'h02;
    end else if (sel.samp >= 5'(ttrc_pkg::SAMP_GAP_LO)) begin
      samp_idx = sel.samp + 5'h01;
    end else begin
      samp_idx = sel.samp;
    end
  end

  logic cmp_lvl_q;
  logic stim_lvl_q;
  logic samp_lvl_q;
  logic cmp_rise;
  logic stim_rise;
  logic samp_rise;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cmp_lvl_q  <= 1'b0;
      stim_lvl_q <= 1'b0;
      samp_lvl_q <= 1'b0;
    end else begin
      cmp_lvl_q  <= tap[cmp_idx];
      stim_lvl_q <= tap[stim_idx];
      samp_lvl_q <= tap[samp_idx];
    end
  end

  logic cmp_prev_q;
  logic stim_prev_q;
  logic samp_prev_q;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cmp_prev_q  <= 1'b0;
      stim_prev_q <= 1'b0;
      samp_prev_q <= 1'b0;
    end else begin
      cmp_prev_q  <= cmp_lvl_q;
      stim_prev_q <= stim_lvl_q;
      samp_prev_q <= samp_lvl_q;
    end
  end

  assign cmp_rise  = cmp_lvl_q && !cmp_prev_q;
  assign stim_rise = stim_lvl_q && !stim_prev_q;
  assign samp_rise = samp_lvl_q && !samp_prev_q;

  // ----------------------------------------------------------------------------
  // compare strobe delay
  // ----------------------------------------------------------------------------
  logic [ttrc_pkg::DLY_W-1:0] dly_q;
  logic [ttrc_pkg::DLY_W-1:0] dly_load;

  assign dly_load = ({16'h0000, sel.trim} + 24'h000001) << {sel.range, 1'b0};

  // a new strobe edge restarts a delay still running
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dly_q <= '0;
    end else if (samp_rise) begin
      dly_q <= dly_load;
    end else if (dly_q != '0) begin
      dly_q <= dly_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // run flip-flop and lamp
  // ----------------------------------------------------------------------------
  logic run_q;
  logic init_prev_q;
  logic lamp_d;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      init_prev_q <= 1'b1;
    end else begin
      init_prev_q <= init_done_b;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_q <= 1'b0;
    end else if (mode_seq) begin
      run_q <= 1'b1;
    end else if (btn.preset) begin
      run_q <= 1'b0;
    end else if (init_prev_q && !init_done_b) begin
      run_q <= 1'b1;
    end
  end

  // lamp dark whenever master is clear, so halt and fault clear darken it
  assign lamp_d = master_q && run_q
                  && (!fail || tap[ttrc_pkg::FLASH_TAP]);

  // ----------------------------------------------------------------------------
  // outputs toward comparators, adapter and boards
  // ----------------------------------------------------------------------------
  logic [ttrc_pkg::SEQ_W-1:0] seq_q;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      seq_q <= '0;
    end else if (mode_seq && stim_rise) begin
      seq_q <= seq_q + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RUN_LAMP   <= 1'b0;
      CMP_STEP   <= 1'b0;
      SAMPLE_CLK <= 1'b0;
      SAMPLE_STB <= 1'b0;
      STIM_CLK   <= 1'b0;
      STIM_CLK_B <= 1'b1;
      SYNC_OUT   <= 1'b0;
      HOLD_OUT   <= 1'b0;
      SEQ_OUT    <= '0;
      REF_DRIVE  <= '0;
      DUT_DRIVE  <= '0;
    end else begin
      RUN_LAMP   <= lamp_d;
      CMP_STEP   <= cmp_rise && mode_seq;
      SAMPLE_CLK <= samp_lvl_q;
      SAMPLE_STB <= (dly_q == 24'h000001);
      STIM_CLK   <= stim_lvl_q;
      STIM_CLK_B <= !stim_lvl_q;
      SYNC_OUT   <= sync_ret;
      HOLD_OUT   <= hold_ret;
      SEQ_OUT    <= seq_q;
      REF_DRIVE  <= gen_out;
      DUT_DRIVE  <= gen_out;
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------------
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic [31:0] wmask;

  assign S_AXI_AWREADY = !aw_got_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_got_q && !S_AXI_BVALID;
  assign do_write      = aw_got_q && w_got_q && !S_AXI_BVALID;
  assign wmask         = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_q <= 1'b1;
      awaddr_q <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      w_got_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_q <= 1'b1;
      wdata_q <= S_AXI_WDATA;
      wstrb_q <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q       <= ttrc_pkg::CTRL_RST;
      rate_q       <= ttrc_pkg::RATE_RST;
      delay_q      <= ttrc_pkg::DELAY_RST;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= ttrc_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= ttrc_pkg::RESP_OKAY;
      if (awaddr_q == ttrc_pkg::REG_CTRL) begin
        ctrl_q <= ((ctrl_q & ~wmask) | (wdata_q & wmask)) & 32'h0000_0001;
      end else if (awaddr_q == ttrc_pkg::REG_RATE) begin
        rate_q <= ((rate_q & ~wmask) | (wdata_q & wmask)) & 32'h001F_0F0F;
      end else if (awaddr_q == ttrc_pkg::REG_DELAY) begin
        delay_q <= ((delay_q & ~wmask) | (wdata_q & wmask)) & 32'h0000_07FF;
      end else if (awaddr_q == ttrc_pkg::REG_STAT || awaddr_q == ttrc_pkg::REG_SEQ) begin
        S_AXI_BRESP <= ttrc_pkg::RESP_OKAY;
      end else begin
        S_AXI_BRESP <= ttrc_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  logic [31:0] stat_word;

  assign stat_word = 32'({fail, lamp_d, run_q, gate_q, master_q});
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= ttrc_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= ttrc_pkg::RESP_OKAY;
      if (S_AXI_ARADDR == ttrc_pkg::REG_CTRL) begin
        S_AXI_RDATA <= ctrl_q;
      end else if (S_AXI_ARADDR == ttrc_pkg::REG_RATE) begin
        S_AXI_RDATA <= rate_q;
      end else if (S_AXI_ARADDR == ttrc_pkg::REG_DELAY) begin
        S_AXI_RDATA <= delay_q;
      end else if (S_AXI_ARADDR == ttrc_pkg::REG_STAT) begin
        S_AXI_RDATA <= stat_word;
      end else if (S_AXI_ARADDR == ttrc_pkg::REG_SEQ) begin
        S_AXI_RDATA <= 32'(seq_q);
      end else begin
        S_AXI_RDATA <= '0;
        S_AXI_RRESP <= ttrc_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

// ==== verif/ttrc_assertions.sv ====
// concurrent checks on the tester timing and run control ports
// assumes it is bound to ttrc_top and sees only that module's ports
`timescale 1ns/1ps

module ttrc_assertions (
  input wire logic                          REF_CLK,
  input wire logic                          RST_B,
  input wire ttrc_pkg::ttrc_btn_t           BTN,
  input wire logic                          SYNC_RET,
  input wire logic                          HOLD_RET,
  input wire logic [ttrc_pkg::GEN_OUTS-1:0] GEN_OUT,
  input wire logic                          RUN_LAMP,
  input wire logic                          CMP_STEP,
  input wire logic                          SAMPLE_CLK,
  input wire logic                          SAMPLE_STB,
  input wire logic                          STIM_CLK,
  input wire logic                          STIM_CLK_B,
  input wire logic                          SYNC_OUT,
  input wire logic                          HOLD_OUT,
  input wire logic [ttrc_pkg::SEQ_W-1:0]    SEQ_OUT,
  input wire logic [ttrc_pkg::GEN_OUTS-1:0] REF_DRIVE,
  input wire logic [ttrc_pkg::GEN_OUTS-1:0] DUT_DRIVE
);
  // ----------------------------------------------------------------------------
  // helper counters: cycles since reset, cycles a stop button is held
  // ----------------------------------------------------------------------------
  logic [2:0] up_q;
  logic [5:0] stop_q;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      up_q   <= 3'h0;
      stop_q <= 6'h00;
    end else begin
      up_q   <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
      stop_q <= !(BTN.halt | BTN.fault_clr) ? 6'h00 : (stop_q == 6'h3F) ? stop_q : stop_q + 6'h01;
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  a_stim_inverse: assert property (STIM_CLK_B == !STIM_CLK) else $error("stimulus inverse wrong");
  a_fanout_equal: assert property (REF_DRIVE == DUT_DRIVE) else $error("fan-out copies differ");
  a_fanout_delay: assert property (up_q >= 3'h4 |-> REF_DRIVE == $past(GEN_OUT, 3))
    else $error("fan-out does not follow generator");
  a_sync_route: assert property (up_q >= 3'h4 |-> SYNC_OUT == $past(SYNC_RET, 3)) else $error("sync route");
  a_hold_route: assert property (up_q >= 3'h4 |-> HOLD_OUT == $past(HOLD_RET, 3)) else $error("hold route");
  a_strobe_pulse: assert property (SAMPLE_STB |=> !SAMPLE_STB) else $error("strobe longer than a cycle");
  a_step_pulse: assert property (CMP_STEP |=> !CMP_STEP) else $error("step longer than a cycle");
  a_stop_darkens: assert property (stop_q >= 6'h05 |-> !RUN_LAMP) else $error("lamp lit while stopped");
  a_stop_freezes: assert property (stop_q >= 6'h28 |-> $stable(STIM_CLK) && $stable(SAMPLE_CLK))
    else $error("rates run while stopped");
  a_seq_counts: assert property ($changed(SEQ_OUT) |-> SEQ_OUT == 8'($past(SEQ_OUT) + 8'h01))
    else $error("sequence counter skipped");
endmodule

// ==== verif/ttrc_board_model.sv ====
// far-side model: pattern generators, init handshake, failure line, adapter returns
// assumes the block's stimulus clock and sequence counter drive it
`timescale 1ns/1ps

module ttrc_board_model (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          stim_clk,
  input  wire logic                          init_req,
  input  wire logic                          fail_req,
  input  wire logic [ttrc_pkg::SEQ_W-1:0]    seq,
  output logic      [ttrc_pkg::GEN_OUTS-1:0] gen_out,
  output logic                               init_done_b,
  output logic                               fail,
  output logic                               sync_ret,
  output logic                               hold_ret
);
  logic       stim_q;
  logic [2:0] wait_q;
  logic       rise;
  assign rise     = stim_clk & ~stim_q;
  assign fail     = fail_req;
  assign sync_ret = seq[0];
  assign hold_ret = ~seq[1];
  // generators shift on stimulus edges; init done after four of them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stim_q      <= 1'b0;
      gen_out     <= {ttrc_pkg::GEN_OUTS{1'b1}};
      wait_q      <= 3'h4;
      init_done_b <= 1'b1;
    end else begin
      stim_q <= stim_clk;
      if (rise) gen_out <= {gen_out[ttrc_pkg::GEN_OUTS-2:0], gen_out[4] ^ gen_out[22]};
      if (!init_req) begin
        wait_q      <= 3'h4;
        init_done_b <= 1'b1;
      end else if (rise && wait_q != 3'h0) wait_q <= wait_q - 3'h1;
      else if (wait_q == 3'h0) init_done_b <= 1'b0;
    end
  end
endmodule

// ==== verif/test_tester_timing_run_control.sv ====
// self-checking bench for the tester timing and run control
// assumes ttrc_top, the board model and the checker are compiled first
`timescale 1ns/1ps

module test_tester_timing_run_control;
  logic ref_clk, rst_b, init_req, fail_req, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, run_lamp, stim_clk, sample_clk, sample_stb;
  logic init_done_b, fail, sync_ret, hold_ret;
  logic [7:0] awaddr, araddr, seq_out;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [65:0] gen_out;
  ttrc_pkg::ttrc_btn_t btn;
  int miscompares, num_checks;

  ttrc_top ttrc_top_inst (.REF_CLK(ref_clk), .RST_B(rst_b), .BTN(btn), .INIT_DONE_B(init_done_b), .FAIL(fail),
    .SYNC_RET(sync_ret), .HOLD_RET(hold_ret), .GEN_OUT(gen_out), .RUN_LAMP(run_lamp), .CMP_STEP(),
    .SAMPLE_CLK(sample_clk), .SAMPLE_STB(sample_stb), .STIM_CLK(stim_clk), .STIM_CLK_B(), .SYNC_OUT(),
    .HOLD_OUT(), .SEQ_OUT(seq_out), .REF_DRIVE(), .DUT_DRIVE(), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  ttrc_board_model ttrc_board_model_inst (.clk(ref_clk), .rst_b(rst_b), .stim_clk(stim_clk), .init_req(init_req),
    .fail_req(fail_req), .seq(seq_out), .gen_out(gen_out), .init_done_b(init_done_b), .fail(fail),
    .sync_ret(sync_ret), .hold_ret(hold_ret));

  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ha, hw, b;
    logic [1:0] rr;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; b = 1'b0; rr = 2'h0;
    for (int i = 0; i < 50 && !b; i++) begin
      @(negedge ref_clk); ha = awvalid & awready; hw = wvalid & wready; b = bvalid; rr = bresp;
      @(posedge ref_clk); if (ha) awvalid <= 1'b0; if (hw) wvalid <= 1'b0;
    end
    chk({31'h0, b}, 32'h1);
    chk({30'h0, rr}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
    logic h, v;
    logic [31:0] d;
    logic [1:0] rr;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; v = 1'b0; d = '0; rr = 2'h0;
    for (int i = 0; i < 50 && !v; i++) begin
      @(negedge ref_clk); h = arvalid & arready; v = rvalid; d = rdata; rr = rresp;
      @(posedge ref_clk); if (h) arvalid <= 1'b0;
    end
    chk({31'h0, v}, 32'h1);
    chk(d & m, e);
    chk({30'h0, rr}, {30'h0, r});
  endtask
  task automatic press(input ttrc_pkg::ttrc_btn_t b, input int n);
    btn <= b;
    repeat (n) @(posedge ref_clk);
    btn <= '0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic lamp_on();
    for (int i = 0; i < 3000 && run_lamp !== 1'b1; i++) @(posedge ref_clk);
    chk({31'h0, run_lamp}, 32'h1);
  endtask
  // period in cycles between the second and third rising edge of a selected rate
  task automatic meas(input int s, input int e);
    logic p, c;
    int r, n;
    p = 1'b0; r = 0; n = 0;
    for (int i = 0; i < 30000 && r < 3; i++) begin
      @(posedge ref_clk); #1;
      c = (s == 0) ? stim_clk : (s == 1) ? sample_clk : sample_stb;
      if (r == 2) n++;
      if (c && !p) r++;
      p = c;
    end
    chk(n, e);
  endtask
  task automatic conclude();
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    logic [7:0] s0;
    rst_b = 1'b0; init_req = 1'b0; fail_req = 1'b0; btn = '0; awaddr = '0; araddr = '0; wdata = '0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(ttrc_pkg::REG_CTRL, 32'hFFFF_FFFF, ttrc_pkg::CTRL_RST, ttrc_pkg::RESP_OKAY);
    rd(ttrc_pkg::REG_RATE, 32'hFFFF_FFFF, ttrc_pkg::RATE_RST, ttrc_pkg::RESP_OKAY);
    rd(ttrc_pkg::REG_DELAY, 32'hFFFF_FFFF, ttrc_pkg::DELAY_RST, ttrc_pkg::RESP_OKAY);
    rd(ttrc_pkg::REG_STAT, 32'h0000_001F, 32'h0, ttrc_pkg::RESP_OKAY);
    rd(8'h20, 32'hFFFF_FFFF, 32'h0, ttrc_pkg::RESP_SLVERR);
    wr(8'h24, 32'h1, ttrc_pkg::RESP_SLVERR);
    wr(ttrc_pkg::REG_DELAY, 32'h0000_0103, ttrc_pkg::RESP_OKAY);
    press('{preset: 1'b1, default: 1'b0}, 4);
    repeat (40) @(posedge ref_clk);
    rd(ttrc_pkg::REG_STAT, 32'h0000_000F, 32'h0000_0003, ttrc_pkg::RESP_OKAY);
    init_req <= 1'b1;
    lamp_on();
    rd(ttrc_pkg::REG_STAT, 32'h0000_000F, 32'h0000_000F, ttrc_pkg::RESP_OKAY);
    fail_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, run_lamp}, 32'h0);
    fail_req <= 1'b0;
    lamp_on();
    meas(0, 200);
    meas(1, 25);
    meas(2, 25);
    wr(ttrc_pkg::REG_RATE, 32'h0007_0100, ttrc_pkg::RESP_OKAY);
    meas(0, 800);
    meas(1, 6400);
    wr(ttrc_pkg::REG_RATE, 32'h0, ttrc_pkg::RESP_OKAY);
    wr(ttrc_pkg::REG_CTRL, 32'h1, ttrc_pkg::RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      press('{halt: k == 0, fault_clr: k != 0, default: 1'b0}, 50);
      chk({31'h0, run_lamp}, 32'h0);
      rd(ttrc_pkg::REG_STAT, 32'h0000_0005, 32'h0000_0004, ttrc_pkg::RESP_OKAY);
      press('{start: 1'b1, default: 1'b0}, 4);
      lamp_on();
    end
    @(posedge stim_clk);
    repeat (5) @(posedge ref_clk);
    s0 = seq_out;
    @(posedge stim_clk);
    repeat (5) @(posedge ref_clk);
    chk({24'h0, seq_out}, {24'h0, 8'(s0 + 8'h01)});
    conclude();
  end
endmodule

bind ttrc_top ttrc_assertions ttrc_assertions_inst (.REF_CLK(REF_CLK), .RST_B(RST_B), .BTN(BTN),
  .SYNC_RET(SYNC_RET), .HOLD_RET(HOLD_RET), .GEN_OUT(GEN_OUT), .RUN_LAMP(RUN_LAMP), .CMP_STEP(CMP_STEP),
  .SAMPLE_CLK(SAMPLE_CLK), .SAMPLE_STB(SAMPLE_STB), .STIM_CLK(STIM_CLK), .STIM_CLK_B(STIM_CLK_B),
  .SYNC_OUT(SYNC_OUT), .HOLD_OUT(HOLD_OUT), .SEQ_OUT(SEQ_OUT), .REF_DRIVE(REF_DRIVE), .DUT_DRIVE(DUT_DRIVE));
